// ==== design/agp_port_pkg.sv ====
// constants, codes and state type for the graphics target port
// assumes one graphics master on the port and a memory agent on sys_clk
// Behaviour
// RULE_01: target ready asserts only when the bridge can finish a data phase now.
// RULE_02: stop ends framed transactions only; never driven during graphics transactions.
// RULE_03: the master asks for the port by asserting its request input.
// RULE_04: the arbiter grants the port and drives three status bits alongside.
// RULE_05: one parity bit covers data and command lines, framed transactions only.
// RULE_06: every address presented while pipe request is asserted is queued; the code does not queue it while the queue is full.
// RULE_07: four-byte sideband address requests are accepted and queued.
// RULE_08: low-priority read data waits while the master's read buffer is full.
// RULE_09: status bits carry meaning only while grant is asserted.
// RULE_10: the data source drives the data strobes timing its data.
// RULE_11: both data strobes carry identical waveforms.
// RULE_12: sideband bytes are captured on edges of the master's sideband strobe.
// RULE_13: framed address comes with frame assertion, data in the following clocks.
// RULE_14: command lines carry commands with requests, byte enables with write data.
// RULE_15: the initiator asserts its ready only when prepared to transfer.
// RULE_16: memory accesses are claimed with device select at medium decode timing; the code does not claim them while the queue is full.
// RULE_17: status uses the standard encodings and shows idle when nothing is granted.
package agp_port_pkg;
  // status codes
  localparam logic [2:0] ST_LOW_READ = 3'h0;
  localparam logic [2:0] ST_START_OP = 3'h7;
  localparam logic [2:0] ST_IDLE = 3'h7;
  // queue entry kinds
  localparam logic [1:0] KIND_PIPE = 2'h0;
  localparam logic [1:0] KIND_SIDEBAND = 2'h1;
  localparam logic [1:0] KIND_PCI_ADDR = 2'h2;
  localparam logic [1:0] KIND_PCI_WRITE = 2'h3;
  // command decode
  localparam logic [2:0] CMD_MEM_RW = 3'h3;
  localparam logic [1:0] CMD_MEM_EXT = 2'h3;
  localparam logic [3:0] CMD_SIDEBAND = 4'h0;
  // request queue
  localparam int QUEUE_DEPTH = 8;
  localparam logic [3:0] QUEUE_FULL_LEVEL = 4'h8;
  localparam logic [3:0] GRANT_DROP_LEVEL = 4'h6;
  localparam logic [1:0] SB_LAST_BYTE = 2'h3;
  typedef enum logic [2:0] {
    LINK_IDLE, LINK_GRANT, LINK_DECODE, LINK_DATA, LINK_TURN, LINK_RD_STATUS, LINK_RD_DATA
  } link_state_type;
endpackage

// ==== design/agp_target_port.sv ====
// graphics port target: arbiter, request queue, framed target, read return
// port_clk is the bus clock; memory side runs on sys_clk, words cross by toggles
`timescale 1ns/1ps
`default_nettype none
module agp_target_port (
  // clocks and reset
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic port_clk,
  // arbitration
  input wire logic port_request_n,
  output logic port_grant_n,
  output logic [2:0] port_status,
  // pipelined and sideband requests
  input wire logic pipe_request_n,
  input wire logic read_buffer_full_n,
  input wire logic [7:0] sideband_addr,
  input wire logic sideband_strobe,
  // address/data and command
  input wire logic [31:0] port_addr_data_in,
  output logic [31:0] port_addr_data_out,
  output logic port_addr_data_oe,
  input wire logic [3:0] port_cmd_byte_en_n,
  input wire logic port_parity_in,
  output logic port_parity_out,
  output logic port_parity_oe,
  output logic data_strobe_a_out,
  output logic data_strobe_b_out,
  output logic data_strobe_oe,
  // framed transaction control
  input wire logic port_frame_n,
  input wire logic port_initiator_ready_n,
  output logic port_target_ready_n,
  output logic port_target_stop_n,
  output logic port_device_select_n,
  output logic target_ctl_oe,
  output logic parity_error,
  // memory side
  output logic mem_req_valid,
  output logic [1:0] mem_req_kind,
  output logic [3:0] mem_req_be_n,
  output logic [31:0] mem_req_word,
  input wire logic mem_rd_valid,
  input wire logic [31:0] mem_rd_data,
  output logic mem_rd_ready
);
  agp_port_pkg::link_state_type state, next_state;
  logic [37:0] queue_mem [0:agp_port_pkg::QUEUE_DEPTH-1];
  logic [3:0] wr_ptr, rd_ptr;
  logic [31:0] addr_reg, rd_data, xfer_word, sb_word, wr_word, rd_hold;
  logic [3:0] cmd_reg, xfer_be_n, wr_be_n;
  logic [1:0] xfer_kind, sb_count;
  logic frame_d, served, rd_pending, rd_for_pci, sb_full, wr_check;
  logic req_toggle, ack_s1, ack_s2, rd_s1, rd_s2, rd_seen;
  logic [2:0] sb_strobe_s;
  logic [7:0] sb_s1, sb_s2;
  logic req_s1, req_s2, req_seen, rd_toggle, rd_ack_s1, rd_ack_s2;

  // decode and selection
  wire [3:0] q_level = wr_ptr - rd_ptr;
  wire q_full = q_level == agp_port_pkg::QUEUE_FULL_LEVEL;
  wire q_empty = q_level == 4'h0;
  wire room = q_level < agp_port_pkg::GRANT_DROP_LEVEL;
  wire is_write = cmd_reg[0];
  wire frame_start = !port_frame_n && frame_d;
  wire mem_cmd = port_cmd_byte_en_n[3:1] == agp_port_pkg::CMD_MEM_RW ||
    port_cmd_byte_en_n[3:2] == agp_port_pkg::CMD_MEM_EXT;
  wire claim = frame_start && mem_cmd && !q_full; // [RULE_16]
  wire data_xfer = state == agp_port_pkg::LINK_DATA && !port_initiator_ready_n &&
    !port_target_ready_n; // [RULE_15]
  wire push_pipe = !pipe_request_n && !q_full; // [RULE_06]
  wire push_addr = state == agp_port_pkg::LINK_DECODE;
  wire push_wr = data_xfer && is_write;
  wire pci_busy = state == agp_port_pkg::LINK_DECODE || state == agp_port_pkg::LINK_DATA;
  wire push_sb = sb_full && !push_pipe && !pci_busy && !q_full; // [RULE_07]
  wire push_any = push_pipe || push_addr || push_wr || push_sb;
  // command lines hold the command on requests, byte enables on write data
  wire [37:0] push_entry = push_pipe ? // [RULE_14]
    {agp_port_pkg::KIND_PIPE, port_cmd_byte_en_n, port_addr_data_in} :
    push_addr ? {agp_port_pkg::KIND_PCI_ADDR, cmd_reg, addr_reg} :
    push_wr ? {agp_port_pkg::KIND_PCI_WRITE, port_cmd_byte_en_n, port_addr_data_in} :
    {agp_port_pkg::KIND_SIDEBAND, agp_port_pkg::CMD_SIDEBAND, sb_word};
  wire pop = !q_empty && req_toggle == ack_s2;
  wire sb_edge = sb_strobe_s[1] && !sb_strobe_s[2]; // [RULE_12]
  wire rd_arrive = rd_s2 != rd_seen && !rd_pending;
  wire agp_return = rd_pending && !rd_for_pci && read_buffer_full_n; // [RULE_08]
  wire next_in_data = next_state == agp_port_pkg::LINK_DATA;
  wire able = is_write ? room : rd_pending && rd_for_pci && !served && !data_xfer; // [RULE_01]
  wire hold_stop = state == agp_port_pkg::LINK_DATA && !port_target_stop_n;
  // stop only inside framed data phases
  wire want_stop = next_in_data && (hold_stop || !able && (is_write || served)); // [RULE_02]
  wire next_trdy = next_in_data && able && !want_stop ||
    next_state == agp_port_pkg::LINK_RD_DATA;
  wire next_grant = next_state == agp_port_pkg::LINK_GRANT ||
    next_state == agp_port_pkg::LINK_RD_STATUS; // [RULE_04]
  wire [2:0] next_status = next_state == agp_port_pkg::LINK_RD_STATUS ?
    agp_port_pkg::ST_LOW_READ : next_grant ? agp_port_pkg::ST_START_OP :
    agp_port_pkg::ST_IDLE; // [RULE_09] [RULE_17]
  wire drive_read = next_in_data && !is_write || next_state == agp_port_pkg::LINK_RD_DATA;

  always_comb
  begin
    next_state = state;
    case (state)
      agp_port_pkg::LINK_IDLE:
        if (claim)
          next_state = agp_port_pkg::LINK_DECODE;
        else if (agp_return)
          next_state = agp_port_pkg::LINK_RD_STATUS;
        else if (!port_request_n && room) // [RULE_03]
          next_state = agp_port_pkg::LINK_GRANT;
      agp_port_pkg::LINK_GRANT:
        if (claim)
          next_state = agp_port_pkg::LINK_DECODE;
        else if (!room || port_request_n && pipe_request_n)
          next_state = agp_port_pkg::LINK_IDLE;
      // one wait clock before claiming gives medium decode
      agp_port_pkg::LINK_DECODE: next_state = agp_port_pkg::LINK_DATA; // [RULE_16]
      agp_port_pkg::LINK_DATA:
        if (port_frame_n && (data_xfer || hold_stop))
          next_state = agp_port_pkg::LINK_TURN;
      agp_port_pkg::LINK_TURN: next_state = agp_port_pkg::LINK_IDLE;
      agp_port_pkg::LINK_RD_STATUS: next_state = agp_port_pkg::LINK_RD_DATA;
      agp_port_pkg::LINK_RD_DATA: next_state = agp_port_pkg::LINK_IDLE;
      default: next_state = agp_port_pkg::LINK_IDLE;
    endcase
  end

  // link state and pin drivers
  always_ff @(posedge port_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= agp_port_pkg::LINK_IDLE;
      frame_d <= 1'b1;
      {port_grant_n, port_target_ready_n, port_target_stop_n, port_device_select_n} <= 4'hf;
      port_status <= agp_port_pkg::ST_IDLE;
      port_addr_data_out <= 32'h0;
      {target_ctl_oe, port_addr_data_oe} <= 2'h0;
      {data_strobe_a_out, data_strobe_b_out, data_strobe_oe} <= 3'h0;
    end
    else
    begin
      state <= next_state;
      frame_d <= port_frame_n;
      port_grant_n <= !next_grant;
      port_status <= next_status;
      port_target_ready_n <= !next_trdy;
      port_target_stop_n <= !want_stop;
      port_device_select_n <= !next_in_data;
      target_ctl_oe <= next_in_data || next_state == agp_port_pkg::LINK_TURN ||
        next_state == agp_port_pkg::LINK_RD_DATA;
      port_addr_data_out <= rd_data; // [RULE_13]
      port_addr_data_oe <= drive_read;
      // source drives both strobes as one waveform with its data
      data_strobe_a_out <= next_state == agp_port_pkg::LINK_RD_DATA; // [RULE_10] [RULE_11]
      data_strobe_b_out <= next_state == agp_port_pkg::LINK_RD_DATA; // [RULE_11]
      data_strobe_oe <= next_state == agp_port_pkg::LINK_RD_DATA; // [RULE_10]
    end
  end

  // framed address, read data holding, parity
  always_ff @(posedge port_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      addr_reg <= 32'h0;
      cmd_reg <= 4'h0;
      {served, rd_pending, rd_for_pci, rd_seen} <= 4'h0;
      rd_data <= 32'h0;
      {port_parity_out, port_parity_oe, wr_check, parity_error} <= 4'h0;
      wr_word <= 32'h0;
      wr_be_n <= 4'h0;
    end
    else
    begin
      if (claim)
      begin
        addr_reg <= port_addr_data_in; // [RULE_13]
        cmd_reg <= port_cmd_byte_en_n; // [RULE_14]
      end
      if (push_addr)
        served <= 1'b0;
      else if (data_xfer && !is_write)
        served <= 1'b1;
      if (push_addr && !is_write)
        rd_for_pci <= 1'b1;
      if (rd_arrive)
      begin
        rd_pending <= 1'b1;
        rd_data <= rd_hold;
        rd_seen <= rd_s2;
      end
      else if (data_xfer && !is_write || state == agp_port_pkg::LINK_RD_DATA)
      begin
        rd_pending <= 1'b0;
        rd_for_pci <= 1'b0;
      end
      // parity follows each framed data phase by one clock, none in graphics mode
      port_parity_out <= ^{port_addr_data_out, port_cmd_byte_en_n}; // [RULE_05]
      port_parity_oe <= state == agp_port_pkg::LINK_DATA && !is_write; // [RULE_05]
      wr_check <= push_wr;
      wr_word <= port_addr_data_in;
      wr_be_n <= port_cmd_byte_en_n;
      parity_error <= wr_check && (^{wr_word, wr_be_n} != port_parity_in); // [RULE_05]
    end
  end

  // request queue and sideband assembly
  always_ff @(posedge port_clk)
  begin
    if (push_any)
      queue_mem[wr_ptr[2:0]] <= push_entry;
  end

  always_ff @(posedge port_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_ptr <= 4'h0;
      rd_ptr <= 4'h0;
      req_toggle <= 1'b0;
      {xfer_kind, xfer_be_n, xfer_word} <= 38'h0;
      sb_strobe_s <= 3'h0;
      sb_s1 <= 8'h0;
      sb_s2 <= 8'h0;
      sb_word <= 32'h0;
      sb_count <= 2'h0;
      sb_full <= 1'b0;
      {ack_s1, ack_s2, rd_s1, rd_s2} <= 4'h0;
    end
    else
    begin
      if (push_any)
        wr_ptr <= wr_ptr + 4'h1; // [RULE_06]
      if (pop)
      begin
        {xfer_kind, xfer_be_n, xfer_word} <= queue_mem[rd_ptr[2:0]];
        rd_ptr <= rd_ptr + 4'h1;
        req_toggle <= !req_toggle;
      end
      sb_strobe_s <= {sb_strobe_s[1:0], sideband_strobe};
      sb_s1 <= sideband_addr;
      sb_s2 <= sb_s1;
      // bytes arrive low first; a word not yet queued is overwritten
      if (sb_edge)
      begin
        sb_word <= {sb_s2, sb_word[31:8]}; // [RULE_12]
        sb_count <= sb_count + 2'h1;
      end
      if (sb_edge && sb_count == agp_port_pkg::SB_LAST_BYTE)
        sb_full <= 1'b1;
      else if (push_sb)
        sb_full <= 1'b0;
      {ack_s1, ack_s2} <= {req_seen, ack_s1};
      {rd_s1, rd_s2} <= {rd_toggle, rd_s1};
    end
  end

  // memory side: one request word and one read word in flight each way
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      {req_s1, req_s2, req_seen} <= 3'h0;
      mem_req_valid <= 1'b0;
      mem_req_kind <= 2'h0;
      mem_req_be_n <= 4'h0;
      mem_req_word <= 32'h0;
      {rd_ack_s1, rd_ack_s2, rd_toggle} <= 3'h0;
      rd_hold <= 32'h0;
      mem_rd_ready <= 1'b0;
    end
    else
    begin
      {req_s1, req_s2} <= {req_toggle, req_s1};
      mem_req_valid <= req_s2 != req_seen;
      if (req_s2 != req_seen)
      begin
        req_seen <= req_s2;
        mem_req_kind <= xfer_kind;
        mem_req_be_n <= xfer_be_n;
        mem_req_word <= xfer_word;
      end
      {rd_ack_s1, rd_ack_s2} <= {rd_seen, rd_ack_s1};
      if (mem_rd_valid && mem_rd_ready)
      begin
        rd_toggle <= !rd_toggle;
        rd_hold <= mem_rd_data;
      end
      mem_rd_ready <= rd_ack_s2 == rd_toggle && !(mem_rd_valid && mem_rd_ready);
    end
  end
endmodule
`default_nettype wire

// ==== tb/agp_port_props.sv ====
// assertion checker for the graphics target port, bound below
// assumes nrst resets the link domain while port_clk runs
`timescale 1ns/1ps
`default_nettype none
module agp_port_props (
  // clock and reset
  input wire logic nrst,
  input wire logic port_clk,
  // arbitration
  input wire logic port_request_n,
  input wire logic port_grant_n,
  input wire logic [2:0] port_status,
  input wire logic read_buffer_full_n,
  // data and control
  input wire logic [31:0] port_addr_data_out,
  input wire logic port_addr_data_oe,
  input wire logic [3:0] port_cmd_byte_en_n,
  input wire logic port_parity_out,
  input wire logic port_parity_oe,
  input wire logic data_strobe_a_out,
  input wire logic data_strobe_b_out,
  input wire logic data_strobe_oe,
  input wire logic port_frame_n,
  input wire logic port_initiator_ready_n,
  input wire logic port_target_ready_n,
  input wire logic port_target_stop_n,
  input wire logic port_device_select_n,
  input wire logic target_ctl_oe
);
  default clocking @(posedge port_clk); endclocking
  default disable iff (!nrst);
  sequence mem_addr_s;
    $fell(port_frame_n) && port_cmd_byte_en_n[3:1] == 3'h3;
  endsequence
  sequence other_addr_s;
    $fell(port_frame_n) && port_cmd_byte_en_n[3:1] != 3'h3 && port_cmd_byte_en_n[3:2] != 2'h3;
  endsequence
  sequence read_xfer_s;
    !port_initiator_ready_n && !port_target_ready_n && !port_device_select_n && port_addr_data_oe;
  endsequence
  medium_decode_a: assert property (
    mem_addr_s |=> port_device_select_n ##1 !port_device_select_n)
    else $error("device select not at medium decode");
  no_claim_a: assert property (
    other_addr_s |=> port_device_select_n [*4])
    else $error("non-memory cycle claimed");
  strobes_equal_a: assert property (
    data_strobe_a_out == data_strobe_b_out)
    else $error("data strobes differ");
  idle_status_a: assert property (
    port_grant_n |-> port_status == 3'h7)
    else $error("status not idle without grant");
  stop_gfx_a: assert property (
    data_strobe_oe |-> !(target_ctl_oe && !port_target_stop_n))
    else $error("stop during graphics transfer");
  rbf_hold_a: assert property (
    $fell(port_grant_n) && port_status == 3'h0 |-> $past(read_buffer_full_n))
    else $error("read data granted while buffer full");
  grant_cause_a: assert property (
    $fell(port_grant_n) && port_status == 3'h7 |-> !$past(port_request_n))
    else $error("grant without request");
  read_parity_a: assert property (
    read_xfer_s |=> port_parity_oe
      && port_parity_out == ^{$past(port_addr_data_out), $past(port_cmd_byte_en_n)})
    else $error("read parity wrong");
endmodule
bind agp_target_port agp_port_props props_chk (
  .nrst, .port_clk, .port_request_n, .port_grant_n, .port_status, .read_buffer_full_n,
  .port_addr_data_out, .port_addr_data_oe, .port_cmd_byte_en_n, .port_parity_out,
  .port_parity_oe, .data_strobe_a_out, .data_strobe_b_out, .data_strobe_oe, .port_frame_n,
  .port_initiator_ready_n, .port_target_ready_n, .port_target_stop_n,
  .port_device_select_n, .target_ctl_oe
);
`default_nettype wire

// ==== tb/agp_target_port_tb.sv ====
// bench for the graphics target port with a master model and memory responder
// assumes reads are answered with the inverted request word
`timescale 1ns/1ps
`default_nettype none
module agp_target_port_tb;
  logic sys_clk = 1'b0;
  logic port_clk = 1'b0;
  logic nrst = 1'b0;
  logic read_buffer_full_n = 1'b1;
  logic mem_rd_valid = 1'b0;
  logic [31:0] mem_rd_data = 32'h0;
  logic seen = 1'b0;
  logic took = 1'b0;
  logic par_seen = 1'b0;
  logic port_request_n, port_grant_n, pipe_request_n, sideband_strobe, port_addr_data_oe;
  logic port_parity_in, port_parity_out, port_parity_oe, data_strobe_a_out, data_strobe_b_out;
  logic data_strobe_oe, port_frame_n, port_initiator_ready_n, port_target_ready_n;
  logic port_target_stop_n, port_device_select_n, target_ctl_oe, parity_error;
  logic mem_req_valid, mem_rd_ready;
  logic [1:0] mem_req_kind;
  logic [2:0] port_status;
  logic [3:0] port_cmd_byte_en_n, mem_req_be_n;
  logic [7:0] sideband_addr;
  logic [31:0] port_addr_data_in, port_addr_data_out, mem_req_word;
  int err_count = 0;
  int comparisons = 0;
  int req_count = 0;
  always #50 sys_clk = ~sys_clk;
  always #80 port_clk = ~port_clk;
  agp_target_port DUT (.*);
  gfx_master_model m (.*);
  always @(posedge sys_clk)
  begin
    took <= mem_rd_valid && mem_rd_ready;
    seen <= mem_req_valid;
    if (mem_req_valid) req_count <= req_count + 1;
  end
  // parity errors last one link cycle; keep them until checked
  always @(posedge port_clk)
  begin
    if (parity_error)
      par_seen <= 1'b1;
  end
  always @(negedge sys_clk)
  begin
    if (took) mem_rd_valid = 1'b0;
    if (seen && (mem_req_kind == 2'h0 || mem_req_kind == 2'h2 && mem_req_be_n == 4'h6))
    begin
      mem_rd_valid = 1'b1;
      mem_rd_data = ~mem_req_word;
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wait_reqs(input int n);
    for (int k = 0; k < 100 && req_count < n; k++)
      @(posedge sys_clk);
    @(negedge sys_clk);
    if (req_count < n)
    begin
      err_count++;
      print_verdict;
    end
  endtask
  task automatic framed_write;
    logic [31:0] rd;
    logic ok;
    int base;
    base = req_count;
    m.framed(4'h7, 32'h0000_1000, 32'hcafe_0001, rd, ok);
    check(32'(ok), 32'h1);
    if (!ok)
      print_verdict;
    wait_reqs(base + 2);
    check(32'(mem_req_kind), 32'h3);
    check(mem_req_word, 32'hcafe_0001);
    check(32'(mem_req_be_n), 32'h0);
    check(32'(par_seen), 32'h0);
    m.bad_parity = 1'b1;
    m.framed(4'h7, 32'h0000_1004, 32'hcafe_0002, rd, ok);
    m.bad_parity = 1'b0;
    check(32'(ok), 32'h1);
    repeat (2) @(negedge port_clk);
    check(32'(par_seen), 32'h1);
  endtask
  task automatic framed_read;
    logic [31:0] rd;
    logic ok;
    m.framed(4'h6, 32'h0000_2000, 32'h0, rd, ok);
    check(32'(ok), 32'h1);
    if (!ok)
      print_verdict;
    check(rd, 32'hffff_dfff);
  endtask
  task automatic other_command;
    logic [31:0] rd;
    logic ok;
    m.framed(4'h2, 32'h0000_0040, 32'h0, rd, ok);
    check(32'(ok), 32'h0);
  endtask
  task automatic held_return;
    logic [31:0] rd;
    logic ok;
    realtime t0;
    @(negedge port_clk);
    read_buffer_full_n = 1'b0;
    t0 = $realtime;
    fork
      m.pipe_read(32'h0000_3000, rd, ok);
      begin
        repeat (20) @(negedge port_clk);
        read_buffer_full_n = 1'b1;
      end
    join
    check(32'(ok), 32'h1);
    if (!ok)
      print_verdict;
    check(rd, 32'hffff_cfff);
    check(32'($realtime - t0 > 3200.0), 32'h1);
  endtask
  task automatic sideband_word;
    int base;
    base = req_count;
    m.sideband(32'h1234_5678);
    wait_reqs(base + 1);
    check(32'(mem_req_kind), 32'h1);
    check(mem_req_word, 32'h1234_5678);
  endtask
  initial
  begin
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    nrst = 1'b1;
    repeat (3) @(posedge port_clk);
    @(negedge port_clk);
    check(32'({port_grant_n, port_status, data_strobe_oe, target_ctl_oe}), 32'h3c);
    framed_write;
    framed_read;
    other_command;
    held_return;
    sideband_word;
    print_verdict;
  end
endmodule
`default_nettype wire

// ==== tb/gfx_master_model.sv ====
// graphics master model: requests, framed cycles and sideband words
// assumes the bench calls one task at a time
`timescale 1ns/1ps
`default_nettype none
module gfx_master_model (
  // link clock
  input wire logic port_clk,
  // requests
  output logic port_request_n,
  output logic pipe_request_n,
  output logic [7:0] sideband_addr,
  output logic sideband_strobe,
  // framed transaction
  output logic [31:0] port_addr_data_in,
  output logic [3:0] port_cmd_byte_en_n,
  output logic port_parity_in,
  output logic port_frame_n,
  output logic port_initiator_ready_n,
  // answers
  input wire logic [31:0] port_addr_data_out,
  input wire logic data_strobe_a_out,
  input wire logic port_target_ready_n
);
  // set by the bench to send one write with wrong parity
  logic bad_parity = 1'b0;
  initial
  begin
    port_request_n = 1'b1;
    pipe_request_n = 1'b1;
    sideband_addr = 8'h00;
    sideband_strobe = 1'b0;
    port_addr_data_in = 32'h0;
    port_cmd_byte_en_n = 4'hf;
    port_parity_in = 1'b0;
    port_frame_n = 1'b1;
    port_initiator_ready_n = 1'b1;
  end
  // single data phase; a read drives the inverted address in its data phase, then the address again
  task automatic framed(input logic [3:0] cmd, input logic [31:0] addr,
    input logic [31:0] wdata, output logic [31:0] rdata, output logic done);
    @(negedge port_clk);
    port_frame_n = 1'b0;
    port_addr_data_in = addr;
    port_cmd_byte_en_n = cmd;
    @(negedge port_clk);
    port_frame_n = 1'b1;
    port_initiator_ready_n = 1'b0;
    port_cmd_byte_en_n = 4'h0;
    port_addr_data_in = cmd[0] ? wdata : ~addr;
    done = 1'b0;
    for (int n = 0; n < 40 && !done; n++)
    begin
      @(posedge port_clk);
      done = !port_target_ready_n;
      rdata = port_addr_data_out;
    end
    @(negedge port_clk);
    port_initiator_ready_n = 1'b1;
    port_parity_in = ^{port_addr_data_in, port_cmd_byte_en_n} ^ bad_parity;
    port_addr_data_in = ~port_addr_data_in;
  endtask
  task automatic pipe_read(input logic [31:0] addr, output logic [31:0] rdata,
    output logic done);
    @(negedge port_clk);
    port_request_n = 1'b0;
    pipe_request_n = 1'b0;
    port_addr_data_in = addr;
    port_cmd_byte_en_n = 4'h0;
    @(negedge port_clk);
    port_request_n = 1'b1;
    pipe_request_n = 1'b1;
    port_addr_data_in = ~addr;
    done = 1'b0;
    for (int n = 0; n < 80 && !done; n++)
    begin
      @(posedge port_clk);
      done = data_strobe_a_out;
      rdata = port_addr_data_out;
    end
  endtask
  // strobe held three link cycles per level to clear the two-flop capture
  task automatic sideband(input logic [31:0] word);
    for (int i = 0; i < 4; i++)
    begin
      @(negedge port_clk);
      sideband_addr = word[8*i +: 8];
      repeat (2) @(negedge port_clk);
      sideband_strobe = 1'b1;
      repeat (3) @(negedge port_clk);
      sideband_strobe = 1'b0;
    end
    sideband_addr = ~sideband_addr;
  endtask
endmodule
`default_nettype wire
